// ===== logic/flash_erase_controller.sv
// flash page and mass erase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module flash_erase_controller
  import flash_erase_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `ERASE_CYC
)(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // command port
  input  wire cmd_s                   cmd,
  input  wire logic                   unlock,
  input  wire logic                   mass_enable,
  input  wire logic [`PAGE_SEL_W-1:0] page_sel,
  input  wire logic                   page_active,
  // protection
  input  wire logic [7:0]             sector_protect,
  input  wire logic                   page_protect,
  input  wire logic                   write_protect,
  // bypass pins
  input  wire logic                   bypass,
  input  wire logic                   pin_page_erase,
  input  wire logic                   pin_mass_erase,
  // read port
  input  wire logic [15:0]            rd_addr,
  output logic [7:0]                  rd_data,
  // status
  output logic                        cpu_stall,
  output logic                        busy,
  output logic                        locked,
  output logic                        done_pulse
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    erase_state_e         state;
    logic                 locked;
    logic [15:0]          addr;
    logic [15:0]          last;
    logic [31:0]          wait_cnt;
    logic                 stall;
    logic                 busy;
    logic                 done;
  } ctrl_s;

  ctrl_s     st_reg;
  ctrl_s     st_next;
  flash_wr_s wr;
  logic      page_ok;
  logic      from_dbg_eff;
  logic      want_page;
  logic      want_mass;

  erase_guard erase_guard_i (
    .page_sel       (page_sel),
    .sector_protect (sector_protect),
    .page_protect   (page_protect),
    .write_protect  (write_protect),
    .from_debug     (from_dbg_eff),
    .page_ok        (page_ok)
  );

  flash_array flash_array_i (
    .clk   (clk),
    .wr    (wr),
    .raddr (rd_addr),
    .rdata (rd_data)
  );

  function automatic logic [15:0] page_base(input logic [`PAGE_SEL_W-1:0] p);
    page_base = {p, `PAGE_ADDR_W'(0)};
  endfunction

  function automatic logic is_cmd(input cmd_s c, input logic [7:0] code);
    is_cmd = c.strobe && (c.data == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command qualification, bypass pins act as debugger-level commands
  assign from_dbg_eff = cmd.from_debug || bypass;
  assign want_page = is_cmd(cmd, `CMD_PAGE_ERASE)
                     || (bypass && pin_page_erase);
  assign want_mass = (is_cmd(cmd, `CMD_MASS_ERASE) && cmd.from_debug)
                     || (bypass && pin_mass_erase);

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    wr           = '0;
    if (unlock && st_reg.state == ST_IDLE) begin
      st_next.locked = 1'b0;
    end
    case (st_reg.state)
      ST_IDLE: begin
        if (!st_reg.locked && want_page && page_active && page_ok) begin
          st_next.state    = ST_PAGE;
          st_next.addr     = page_base(page_sel);
          st_next.last     = page_base(page_sel) + 16'(`PAGE_BYTES - 10'h1);
          st_next.stall    = 1'b1;
          st_next.busy     = 1'b1;
          st_next.wait_cnt = '0;
        end else if (!st_reg.locked && want_mass && mass_enable
                     && (from_dbg_eff || !write_protect)) begin
          st_next.state    = ST_MASS;
          st_next.addr     = '0;
          st_next.last     = 16'(`ARRAY_BYTES - 17'h1);
          st_next.stall    = 1'b1;
          st_next.busy     = 1'b1;
          st_next.wait_cnt = '0;
        end
        // anything else is ignored, contents untouched
      end
      ST_PAGE,
      ST_MASS: begin
        wr.we    = 1'b1;
        wr.addr  = st_reg.addr;
        wr.wdata = `ERASED_BYTE;
        if (st_reg.addr != st_reg.last) begin
          st_next.addr = st_reg.addr + 16'h1;
        end
        if (st_reg.wait_cnt < ERASE_CYCLES - 1) begin
          st_next.wait_cnt = st_reg.wait_cnt + 32'h1;
        end else if (st_reg.addr == st_reg.last) begin
          st_next.state = ST_DONE;
        end
      end
      ST_DONE: begin
        st_next.state  = ST_IDLE;
        st_next.locked = 1'b1;
        st_next.stall  = 1'b0;
        st_next.busy   = 1'b0;
        st_next.done   = 1'b1;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg        <= '0;
      st_reg.state  <= ST_IDLE;
      st_reg.locked <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_stall  = st_reg.stall;
  assign busy       = st_reg.busy;
  assign locked     = st_reg.locked;
  assign done_pulse = st_reg.done;

  ////////////////////////////////////////////////////////////////////////
  // checks: acceptance of commands

  a_page_start: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_next.state == ST_PAGE
      |-> !st_reg.locked && page_active && page_ok)
    else $error("page erase started without preconditions");

  a_page_accept: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !st_reg.locked && want_page && page_active && page_ok
      |=> st_reg.state == ST_PAGE && busy && cpu_stall)
    else $error("valid page erase command not taken");

  a_page_inactive: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !page_active |=> st_reg.state != ST_PAGE)
    else $error("page erase taken with no active page");

  a_page_base: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_next.state == ST_PAGE
      |-> st_next.addr == {page_sel, 9'h000})
    else $error("page erase does not start at selected page");

  a_protect: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !page_ok && !want_mass
      |=> st_reg.state != ST_PAGE)
    else $error("protected page erased");

  a_mass_debug: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_next.state == ST_MASS
      |-> from_dbg_eff && mass_enable)
    else $error("mass erase started outside debugger");

  a_mass_core: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && cmd.strobe && !cmd.from_debug && !bypass
      |=> st_reg.state != ST_MASS)
    else $error("mass erase taken from core");

  a_mass_enable: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !mass_enable |=> st_reg.state != ST_MASS)
    else $error("mass erase taken while not enabled");

  a_mass_span: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_next.state == ST_MASS
      |-> st_next.addr == 16'h0000 && st_next.last == 16'hFFFF)
    else $error("mass erase does not cover whole array");

  a_bypass_page: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !st_reg.locked && bypass && pin_page_erase
      && page_active && page_ok
      |=> st_reg.state == ST_PAGE)
    else $error("bypass page erase not taken");

  a_bypass_mass: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && !st_reg.locked && bypass && pin_mass_erase && mass_enable
      && !(want_page && page_active && page_ok)
      |=> st_reg.state == ST_MASS)
    else $error("bypass mass erase not taken");

  a_locked_idle: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_reg.locked |=> st_reg.state == ST_IDLE)
    else $error("locked controller started erase");

  a_unlock_gate: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE && st_reg.locked && !unlock
      |=> st_reg.locked)
    else $error("lock cleared without unlock");

  ////////////////////////////////////////////////////////////////////////
  // checks: erase sweep

  a_erase_ff: assert property (@(posedge clk) disable iff (!reset_n)
    wr.we |-> wr.wdata == `ERASED_BYTE)
    else $error("erase wrote a non-erased value");

  a_erase_flagged: assert property (@(posedge clk) disable iff (!reset_n)
    wr.we |-> busy && cpu_stall)
    else $error("array written while not busy");

  a_quiet_idle: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_IDLE || st_reg.state == ST_DONE
      |-> !wr.we)
    else $error("array written outside an erase");

  a_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
    wr.we && $past(wr.we)
      |-> wr.addr == $past(wr.addr) + 16'h1 || wr.addr == $past(wr.addr))
    else $error("erase address not ascending");

  a_page_span: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_PAGE
      |-> st_reg.addr[15:9] == st_reg.last[15:9] && st_reg.last[8:0] == 9'h1FF)
    else $error("page span wrong");

  a_span_end: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg.state == ST_PAGE || st_reg.state == ST_MASS) && st_next.state == ST_DONE
      |-> st_reg.addr == st_reg.last && st_reg.wait_cnt >= ERASE_CYCLES - 1)
    else $error("erase ended before its span or time");

  ////////////////////////////////////////////////////////////////////////
  // checks: status and relock

  a_stall_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg.state == ST_PAGE || st_reg.state == ST_MASS)
      |-> cpu_stall && busy)
    else $error("core not held during erase");

  a_mass_stall: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_MASS |-> cpu_stall && !locked)
    else $error("core not held during mass erase");

  a_start_stall: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy) |-> cpu_stall && !locked)
    else $error("busy rose without stall");

  a_stall_tracks_busy: assert property (@(posedge clk) disable iff (!reset_n)
    cpu_stall == busy)
    else $error("stall and busy disagree");

  a_busy_hold: assert property (@(posedge clk) disable iff (!reset_n)
    busy |=> busy || done_pulse)
    else $error("busy dropped without completion");

  a_locked_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    locked |-> !busy)
    else $error("busy while locked");

  a_relock_end: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.state == ST_DONE
      |=> locked && !cpu_stall && !busy && done_pulse)
    else $error("no relock after erase");

  a_done_single: assert property (@(posedge clk) disable iff (!reset_n)
    done_pulse |=> !done_pulse)
    else $error("done pulse longer than one cycle");

  a_done_relock: assert property (@(posedge clk) disable iff (!reset_n)
    done_pulse |-> locked && !busy)
    else $error("done without relock");

  a_core_release: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(cpu_stall) |-> done_pulse)
    else $error("core released before erase end");

  ////////////////////////////////////////////////////////////////////////
  // main scenarios
  c_page: cover property (@(posedge clk) st_reg.state == ST_PAGE ##1 st_reg.state == ST_DONE);
  c_mass: cover property (@(posedge clk) st_reg.state == ST_MASS);
  c_bypass: cover property (@(posedge clk) bypass && st_next.state == ST_PAGE);
  c_bypass_mass: cover property (@(posedge clk) bypass && st_next.state == ST_MASS);
  c_refused: cover property (@(posedge clk)
    st_reg.state == ST_IDLE && !st_reg.locked && cmd.strobe && st_next.state == ST_IDLE);
endmodule
`default_nettype wire

// ===== logic/flash_erase_regs.svh
// constants for the flash erase controller
// Notes on behaviour
// - erase works on 512-byte pages
// - page erase leaves page bytes at FFH
// - page number comes from page select
// - pages in protected sectors are refused
// - page erase: unlocked, page set, 95h
// - core held idle during page erase
// - core released once page erase ends
// - page erase end relocks controller
// - mass erase only through debugger
// - mass erase sets whole array FFH
// - mass erase: unlocked, enabled, 63H
// - core held idle during mass erase
// - mass erase end relocks controller
// - bypass hands flash controls to pins
// - both erases work under bypass
// - debugger access ignores write protect
// - protection at page, sector, memory
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define PAGE_BYTES     10'h200
`define PAGE_ADDR_W    9
`define PAGE_SEL_W     7
`define SECTOR_W       3
`define ERASED_BYTE    8'hFF
`define ARRAY_BYTES    17'h10000
`define ERASE_NS       32'h2710
`define CLK_NS         32'h19
`define ERASE_CYC      ((`ERASE_NS + `CLK_NS - 32'h1) / `CLK_NS)
`endif

// ===== logic/flash_erase_pkg.sv
// types for the flash erase controller
`default_nettype none
package flash_erase_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_PAGE, ST_MASS, ST_DONE} erase_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic       strobe;
    logic       from_debug;
  } cmd_s;
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flash_wr_s;
endpackage
`default_nettype wire

// ===== logic/erase_guard.sv
// protection check for an erase request
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module erase_guard
  import flash_erase_pkg::*;
(
  // selection
  input  wire logic [`PAGE_SEL_W-1:0] page_sel,
  input  wire logic [7:0]             sector_protect,
  input  wire logic                   page_protect,
  input  wire logic                   write_protect,
  input  wire logic                   from_debug,
  // result
  output logic                        page_ok
);
  logic [`SECTOR_W-1:0] sector;
  assign sector  = page_sel[`PAGE_SEL_W-1 -: `SECTOR_W];
  // page, sector and whole-memory levels
  assign page_ok = !page_protect && !sector_protect[sector]
                   && (from_debug || !write_protect);
endmodule
`default_nettype wire

// ===== logic/flash_array.sv
// flash array model memory with registered read
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module flash_array
  import flash_erase_pkg::*;
(
  // clock
  input  wire logic        clk,
  // write port
  input  wire flash_wr_s   wr,
  // read port
  input  wire logic [15:0] raddr,
  output logic [7:0]       rdata
);
  logic [7:0] mem [0:`ARRAY_BYTES-1];
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ===== dv/cmd_host.sv
// partner model: core and debugger command side
`timescale 1ns/1ps
`default_nettype none
module cmd_host
  import flash_erase_pkg::*;
(
  // clock
  input  wire logic clk,
  // status seen
  input  wire logic busy,
  // command out
  output var  cmd_s cmd
);
  initial cmd = '0;
  // one-cycle byte write, data scrambled after the strobe
  task automatic issue(input logic [7:0] b, input logic dbg);
    cmd = '{data: b, strobe: 1'b1, from_debug: dbg};
    @(posedge clk);
    #2;
    cmd.strobe = 1'b0;
    cmd.data = ~b;
  endtask
  // status polling until idle, bounded
  task automatic poll(input int lim, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      #2;
      ok = (busy === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/flash_erase_controller_bench.sv
// bench for the flash erase controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module flash_erase_controller_bench;
  localparam int unsigned EC = 4;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   unlock = 1'b0;
  logic                   mass_enable = 1'b0;
  logic                   page_active = 1'b1;
  logic                   page_protect = 1'b0;
  logic                   write_protect = 1'b0;
  logic                   bypass = 1'b0;
  logic                   pin_page_erase = 1'b0;
  logic                   pin_mass_erase = 1'b0;
  logic [`PAGE_SEL_W-1:0] page_sel = 7'h05;
  logic [7:0]             sector_protect = 8'h00;
  logic [15:0]            rd_addr = 16'h0000;
  logic [7:0]             rd_data;
  logic                   cpu_stall, busy, locked, done_pulse;
  flash_erase_pkg::cmd_s  cmd;
  int                     n_fail = 0;
  int                     total_checks = 0;
  always #12.5 clk = ~clk;
  cmd_host cmd_host_i (.clk(clk), .busy(busy), .cmd(cmd));
  flash_erase_controller #(.ERASE_CYCLES(EC)) flash_erase_controller_i (
    .clk(clk), .reset_n(reset_n), .cmd(cmd), .unlock(unlock), .mass_enable(mass_enable),
    .page_sel(page_sel), .page_active(page_active), .sector_protect(sector_protect),
    .page_protect(page_protect), .write_protect(write_protect), .bypass(bypass),
    .pin_page_erase(pin_page_erase), .pin_mass_erase(pin_mass_erase), .rd_addr(rd_addr),
    .rd_data(rd_data), .cpu_stall(cpu_stall), .busy(busy), .locked(locked),
    .done_pulse(done_pulse));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic unlock_it;
    unlock = 1'b1;
    @(posedge clk);
    #2;
    unlock = 1'b0;
    chk("locked", 16'h0000, {15'h0, locked});
  endtask
  // accepted erase: stall and busy until relock
  task automatic run_erase(input logic [7:0] b, input logic dbg, input int lim);
    logic ok;
    unlock_it();
    cmd_host_i.issue(b, dbg);
    chk("busy", 16'h0001, {15'h0, busy});
    chk("cpu_stall", 16'h0001, {15'h0, cpu_stall});
    cmd_host_i.poll(lim, ok);
    chk("finished", 16'h0001, {15'h0, ok});
    chk("done_pulse", 16'h0001, {15'h0, done_pulse});
    chk("locked", 16'h0001, {15'h0, locked});
    chk("cpu_stall", 16'h0000, {15'h0, cpu_stall});
    @(posedge clk);
    #2;
    chk("done_pulse", 16'h0000, {15'h0, done_pulse});
  endtask
  // refused command: nothing starts
  task automatic refused(input logic [7:0] b, input logic dbg);
    cmd_host_i.issue(b, dbg);
    repeat (2) @(posedge clk);
    #2;
    chk("busy", 16'h0000, {15'h0, busy});
    chk("cpu_stall", 16'h0000, {15'h0, cpu_stall});
  endtask
  task automatic rd(input logic [15:0] a);
    rd_addr = a;
    @(posedge clk);
    #2;
    chk("rd_data", {8'h00, `ERASED_BYTE}, {8'h00, rd_data});
  endtask
  task automatic bypass_page;
    logic ok;
    bypass = 1'b1;
    page_sel = 7'h30;
    unlock_it();
    pin_page_erase = 1'b1;
    @(posedge clk);
    #2;
    pin_page_erase = 1'b0;
    chk("busy", 16'h0001, {15'h0, busy});
    cmd_host_i.poll(EC + 600, ok);
    chk("finished", 16'h0001, {15'h0, ok});
    rd(16'h6000);
    bypass = 1'b0;
  endtask
  // bypass mass erase started, then cut short by a mid-run reset
  task automatic bypass_mass_reset;
    bypass = 1'b1;
    pin_mass_erase = 1'b1;
    @(posedge clk);
    #2;
    pin_mass_erase = 1'b0;
    chk("busy", 16'h0001, {15'h0, busy});
    chk("cpu_stall", 16'h0001, {15'h0, cpu_stall});
    repeat (8) @(posedge clk);
    #2;
    chk("busy", 16'h0001, {15'h0, busy});
    bypass = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    reset_n = 1'b1;
    chk("reset", 16'h0004, {13'h0, locked, busy, cpu_stall | done_pulse});
    @(posedge clk);
    #2;
    chk("busy", 16'h0000, {15'h0, busy});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    #2;
    reset_n = 1'b1;
    chk("reset", 16'h0004, {13'h0, locked, busy, cpu_stall | done_pulse});
    refused(8'h95, 1'b0);
    run_erase(8'h95, 1'b0, EC + 600);
    rd(16'h0A00);
    rd(16'h0BFF);
    unlock_it();
    refused(8'h96, 1'b0);
    page_active = 1'b0;
    refused(8'h95, 1'b0);
    page_active = 1'b1;
    page_sel = 7'h25;
    sector_protect = 8'h04;
    refused(8'h95, 1'b0);
    sector_protect = 8'h00;
    page_protect = 1'b1;
    refused(8'h95, 1'b0);
    page_protect = 1'b0;
    write_protect = 1'b1;
    refused(8'h95, 1'b0);
    page_sel = 7'h10;
    run_erase(8'h95, 1'b1, EC + 600);
    rd(16'h2000);
    write_protect = 1'b0;
    bypass_page();
    unlock_it();
    refused(8'h63, 1'b1);
    mass_enable = 1'b1;
    refused(8'h63, 1'b0);
    bypass_mass_reset();
    run_erase(8'h63, 1'b1, 70000);
    rd(16'h0000);
    rd(16'hFFFF);
    rd(16'h5A5A);
    wrap_up();
  end
endmodule
`default_nettype wire
